/* File: core/tcr_pkg.sv */
// Package with constants and carrier types of the thermocouple readout block.
package tcr_pkg;

  // Clock rate and conversion period.
  localparam int unsigned CLK_HZ                 = 250_000_000;
  localparam int unsigned CONVERSION_PERIOD_MS   = 70;
  localparam int unsigned CONVERSION_PERIOD_CYC  = CONVERSION_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned PHASE_CYC              = CONVERSION_PERIOD_CYC / 3;

  // Linear thermocouple gain, type K, in nanovolts per degree (41.276 uV per degree).
  localparam int unsigned TC_GAIN_NV_PER_C       = 41276;
  // Quarter degrees per microvolt of converter code, scaled by two to the TC_GAIN_SHIFT.
  localparam int unsigned TC_GAIN_SHIFT          = 16;
  localparam int unsigned TC_GAIN_NUM            = (4 * 65536 * 1000) / TC_GAIN_NV_PER_C;

  // Output word layout.
  localparam int unsigned WORD_W                 = 32;
  localparam int unsigned TC_W                   = 14;
  localparam int unsigned CJ_W                   = 12;
  localparam int unsigned TC_MSB_POS             = 31;
  localparam int unsigned TC_LSB_POS             = 18;
  localparam int unsigned RSV_HI_POS             = 17;
  localparam int unsigned FAULT_POS              = 16;
  localparam int unsigned CJ_MSB_POS             = 15;
  localparam int unsigned CJ_LSB_POS             = 4;
  localparam int unsigned RSV_LO_POS             = 3;
  localparam int unsigned SCV_POS                = 2;
  localparam int unsigned SCG_POS                = 1;
  localparam int unsigned OC_POS                 = 0;
  localparam logic [13:0] TC_OPEN_PATTERN        = 14'h1FFF;
  localparam logic [13:0] TC_MAX                 = 14'h1FFF;
  localparam logic [13:0] TC_MIN                 = 14'h2000;
  localparam logic [5:0]  BIT_COUNT_END          = 6'h20;

  // Reset values.
  localparam logic [31:0] WORD_RESET             = 32'h0000_0000;

  // Conversion phases.
  typedef enum logic [1:0] {PH_COLD, PH_TC, PH_FAULT} tcr_phase_type;

  // Result word as shifted out, most significant field first.
  typedef struct packed {
    logic [13:0] tc_temp;
    logic        rsv_hi;
    logic        fault_any;
    logic [11:0] cj_temp;
    logic        rsv_lo;
    logic        short_vcc;
    logic        short_gnd;
    logic        open_tc;
  } tcr_word_type;

  // Analog path switch controls, high means closed.
  typedef struct packed {
    logic fault_pos;
    logic fault_neg;
    logic tminus_gnd;
    logic tc_to_adc;
    logic cj_to_adc;
  } tcr_switch_type;

  // Fault comparator levels from the detection circuit.
  typedef struct packed {
    logic short_vcc;
    logic short_gnd;
    logic open_tc;
  } tcr_fault_type;

endpackage

/* File: core/tcr_readout.sv */
// Conversion sequencer, result assembly and serial read-out of the thermocouple readout block.
`timescale 1ns/1ps
module tcr_readout
  import tcr_pkg::*;
#(
  parameter int unsigned PHASE_CYCLES = PHASE_CYC,
  parameter int unsigned ADC_W        = 18,
  parameter int unsigned GAIN_NUM     = TC_GAIN_NUM,
  parameter int unsigned GAIN_SHIFT   = TC_GAIN_SHIFT
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic                    sck,
  input  wire logic                    cs_n,
  output logic                         so,
  output logic                         so_oe,
  output tcr_switch_type               switches,
  output logic                         adc_start,
  input  wire logic                    adc_valid,
  input  wire logic signed [ADC_W-1:0] adc_tc_code,
  input  wire logic signed [CJ_W-1:0]  adc_cj_code,
  input  wire tcr_fault_type           fault_in
);

  localparam int unsigned CNT_W  = $clog2(PHASE_CYCLES + 1);
  localparam int unsigned PROD_W = ADC_W + 32;

  tcr_phase_type         phase_ff;
  tcr_phase_type         nxt_phase;
  logic [CNT_W-1:0]      timer_ff;
  logic                  adc_start_ff;
  tcr_switch_type        switches_ff;
  tcr_switch_type        nxt_switches;
  logic signed [CJ_W-1:0] cj_ff;
  logic signed [TC_W-1:0] tc_ff;
  tcr_fault_type         fault_ff;
  tcr_word_type          result_ff;
  tcr_word_type          nxt_result;
  tcr_word_type          word_ff;
  logic                  so_oe_ff;
  logic [5:0]            bit_cnt_ff;
  logic                  cs_n_sync;
  tcr_fault_type         fault_sync;

  wire                   phase_end;
  wire                   start_conv;
  wire signed [PROD_W-1:0] tc_prod;
  wire signed [PROD_W-1:0] tc_uncomp;
  wire signed [PROD_W-1:0] tc_sum;
  wire signed [TC_W-1:0] tc_sat;
  wire                   cs_high;

  // Chip select and the fault comparators come from outside this clock's domain.
  tcr_sync #(.W(1), .RESET_VAL(1'b1)) u_cs_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .din  (cs_n),
    .dout (cs_n_sync)
  );

  tcr_sync #(.W(3), .RESET_VAL(3'h0)) u_fault_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .din  (fault_in),
    .dout (fault_sync)
  );

  // Phase timing: every phase lasts the same number of cycles, so three make one period.
  assign phase_end  = (timer_ff == CNT_W'(PHASE_CYCLES - 1));
  assign start_conv = phase_end && (nxt_phase != PH_FAULT);

  // Phase order is fixed and free running; no host command is needed.
  always_comb begin
    nxt_phase = phase_ff;
    if (phase_end) begin
      unique case (phase_ff)
        PH_COLD:  nxt_phase = PH_TC;
        PH_TC:    nxt_phase = PH_FAULT;
        PH_FAULT: nxt_phase = PH_COLD;
        default:  nxt_phase = PH_COLD;
      endcase
    end
  end

  // Switch settings of the analog path for the coming phase.
  always_comb begin
    nxt_switches = '0;
    unique case (nxt_phase)
      PH_COLD: begin
        nxt_switches.cj_to_adc  = 1'b1;
        nxt_switches.tminus_gnd = 1'b1;
      end
      PH_TC: begin
        nxt_switches.tc_to_adc  = 1'b1;
        nxt_switches.tminus_gnd = 1'b1;
      end
      PH_FAULT: begin
        nxt_switches.fault_pos  = 1'b1;
        nxt_switches.fault_neg  = 1'b1;
      end
      default: nxt_switches = '0;
    endcase
  end

  // Sequencer registers; switches register from the next phase so they track phase_ff exactly.
  // Reset puts the switches in the cold setting, because the phase itself resets to cold.
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_ff     <= PH_COLD;
      timer_ff     <= '0;
      switches_ff  <= '{fault_pos: 1'b0, fault_neg: 1'b0, tminus_gnd: 1'b1, tc_to_adc: 1'b0, cj_to_adc: 1'b1};
      adc_start_ff <= 1'b0;
    end else if (ce) begin
      phase_ff     <= nxt_phase;
      timer_ff     <= phase_end ? '0 : timer_ff + 1'b1;
      switches_ff  <= nxt_switches;
      adc_start_ff <= start_conv;
    end
  end

  // Linear gain of the variant, then compensation by the die temperature in quarter degrees.
  assign tc_prod   = PROD_W'(adc_tc_code) * $signed(PROD_W'(GAIN_NUM));
  assign tc_uncomp = tc_prod >>> GAIN_SHIFT;
  assign tc_sum    = tc_uncomp + (PROD_W'(cj_ff) >>> 2);
  // Saturate rather than wrap so an overrange reading keeps its sign.
  assign tc_sat    = (tc_sum > $signed(PROD_W'(8191)))  ? $signed(TC_MAX) :
                     (tc_sum < -$signed(PROD_W'(8192))) ? $signed(TC_MIN) : tc_sum[TC_W-1:0];

  // Converter results are taken in the phase that produced them.
  always_ff @(posedge clk) begin
    if (srst) begin
      cj_ff    <= '0;
      tc_ff    <= '0;
      fault_ff <= '0;
    end else if (ce) begin
      if (adc_valid && phase_ff == PH_COLD) begin
        cj_ff <= adc_cj_code;
      end
      if (adc_valid && phase_ff == PH_TC) begin
        tc_ff <= tc_sat;
      end
      if (phase_end && phase_ff == PH_FAULT) begin
        fault_ff <= fault_sync;
      end
    end
  end

  // Result word assembly at the close of a complete period.
  always_comb begin
    nxt_result           = result_ff;
    if (phase_end && phase_ff == PH_FAULT) begin
      nxt_result.tc_temp   = fault_sync.open_tc ? TC_OPEN_PATTERN : tc_ff;
      nxt_result.rsv_hi    = 1'b0;
      nxt_result.fault_any = |fault_sync;
      nxt_result.cj_temp   = cj_ff;
      nxt_result.rsv_lo    = 1'b0;
      nxt_result.short_vcc = fault_sync.short_vcc;
      nxt_result.short_gnd = fault_sync.short_gnd;
      nxt_result.open_tc   = fault_sync.open_tc;
    end
  end

  // The output word follows the result only while deselected and freezes during a read.
  assign cs_high = cs_n_sync;

  always_ff @(posedge clk) begin
    if (srst) begin
      result_ff <= WORD_RESET;
      word_ff   <= WORD_RESET;
      so_oe_ff  <= 1'b0;
    end else if (ce) begin
      result_ff <= nxt_result;
      if (cs_high) begin
        word_ff <= result_ff;
      end
      so_oe_ff  <= ~cs_n_sync;
    end
  end

  // Link side: count falling serial clock edges; chip select high holds the count at zero,
  // so clock edges while deselected have no effect and a short read leaves nothing behind.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_ff <= '0;
    end else if (bit_cnt_ff != BIT_COUNT_END) begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end
  end

  // The frozen word is stable through the read, so selecting a bit across domains is safe.
  // Bit 31 shows as soon as the count is cleared, without any clock edge. Past 32 bits, zeros.
  assign so        = (bit_cnt_ff == BIT_COUNT_END) ? 1'b0 : word_ff[5'h1F - bit_cnt_ff[4:0]];
  assign so_oe     = so_oe_ff;
  assign switches  = switches_ff;
  assign adc_start = adc_start_ff;

  // Phase order is cold junction, thermocouple, fault.
  a_phase_order: assert property (@(posedge clk) disable iff (srst)
    (phase_ff == PH_TC && $past(phase_ff) != PH_TC) |-> $past(phase_ff) == PH_COLD)
    else $error("thermocouple phase not preceded by cold phase");

  a_cold_switches: assert property (@(posedge clk) disable iff (srst)
    phase_ff == PH_COLD |-> switches == 5'h05)
    else $error("cold phase switch setting wrong");

  a_tc_switches: assert property (@(posedge clk) disable iff (srst)
    phase_ff == PH_TC |-> switches == 5'h06)
    else $error("thermocouple phase switch setting wrong");

  a_fault_switches: assert property (@(posedge clk) disable iff (srst)
    phase_ff == PH_FAULT |-> switches == 5'h18)
    else $error("fault phase switch setting wrong");

  a_fault_summary: assert property (@(posedge clk) disable iff (srst)
    result_ff.fault_any == (result_ff.short_vcc | result_ff.short_gnd | result_ff.open_tc))
    else $error("summary fault bit disagrees with fault bits");

  a_open_pattern: assert property (@(posedge clk) disable iff (srst)
    result_ff.open_tc |-> result_ff.tc_temp == 14'h1FFF)
    else $error("open thermocouple pattern wrong");

  a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    word_ff.rsv_hi == 1'b0 && word_ff.rsv_lo == 1'b0)
    else $error("reserved bit not zero");

  a_word_frozen: assert property (@(posedge clk) disable iff (srst)
    (!cs_n_sync && ce) |=> $stable(word_ff))
    else $error("output word changed during a read");

  a_word_follows: assert property (@(posedge clk) disable iff (srst)
    (cs_n_sync && ce) |=> word_ff == $past(result_ff))
    else $error("output word did not load the result");

  a_fault_sample: assert property (@(posedge clk) disable iff (srst)
    (ce && phase_end && phase_ff == PH_FAULT) |=> fault_ff == $past(fault_sync))
    else $error("fault flags not taken at end of fault phase");

  a_conv_restart: assert property (@(posedge clk) disable iff (srst)
    (ce && phase_end && phase_ff != PH_TC) |=> adc_start)
    else $error("conversion not started at phase change");

  a_bit_count: assert property (@(negedge sck) disable iff (cs_n)
    bit_cnt_ff <= BIT_COUNT_END)
    else $error("bit counter past end of word");

endmodule

/* File: core/tcr_sync.sv */
// Three-stage synchroniser that passes a change once the second and third stages agree.
`timescale 1ns/1ps
module tcr_sync
  import tcr_pkg::*;
#(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  wire  [W-1:0] agree;
  wire  [W-1:0] nxt_out;

  // Only stages two and three are compared; the first stage may be metastable.
  assign agree   = ~(s2_ff ^ s3_ff);
  assign nxt_out = (agree & s3_ff) | (~agree & out_ff);
  assign dout    = out_ff;

  // Synchroniser chain and filtered output.
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_ff  <= RESET_VAL;
      s2_ff  <= RESET_VAL;
      s3_ff  <= RESET_VAL;
      out_ff <= RESET_VAL;
    end else if (ce) begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

endmodule

/* File: sim/tcr_host.sv */
// Host model that reads the result word over the serial link, as the far-side master.
`timescale 1ns/1ps
module tcr_host #(
  parameter int HALF_NS = 24
) (
  output logic      sck,
  output logic      cs_n,
  input  wire logic so,
  input  wire logic so_oe
);
  logic [31:0] rx_word;
  logic        oe_all;
  event        got;

  // The serial clock stands low between frames and chip select idles high.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    rx_word = 32'h0000_0000;
    oe_all = 1'b0;
  end

  // One read of n bits; bits are taken just before each rising edge, the device moves on at the fall.
  task automatic read(input int n);
    rx_word = 32'h0000_0000;
    oe_all = 1'b1;
    #7 cs_n = 1'b0;
    #150;
    for (int i = 0; i < n; i++) begin
      oe_all = oe_all & so_oe;
      rx_word = {rx_word[30:0], so};
      sck = 1'b1;
      #HALF_NS sck = 1'b0;
      #HALF_NS;
    end
    cs_n = 1'b1;
    #100;
    -> got;
    #1;
  endtask

  // Clock edges while deselected, which the device must not count.
  task automatic idle_clocks(input int k);
    for (int i = 0; i < k; i++) begin
      #HALF_NS sck = 1'b1;
      #HALF_NS sck = 1'b0;
    end
  endtask
endmodule

/* File: sim/thermocouple_serial_readout_tb.sv */
// Self-checking bench for the thermocouple readout block with a host model on the link.
`timescale 1ns/1ps
module thermocouple_serial_readout_tb;
  import tcr_pkg::*;
  localparam int PH     = 20;
  localparam int SETTLE = 4 * 3 * PH;
  localparam int LIMIT  = 40000;
  logic               clk, srst, ce, sck, cs_n, so, so_oe, adc_start, adc_valid;
  tcr_switch_type     switches;
  logic signed [17:0] tc_code;
  logic signed [11:0] cj_code;
  tcr_fault_type      fault_in;
  logic [31:0]        exp_q[$];
  int                 n_fail, checks_done, cyc, seed;

  always #2 clk = ~clk;

  tcr_readout #(.PHASE_CYCLES(PH)) DUT (
    .clk(clk), .srst(srst), .ce(ce), .sck(sck), .cs_n(cs_n), .so(so), .so_oe(so_oe),
    .switches(switches), .adc_start(adc_start), .adc_valid(adc_valid),
    .adc_tc_code(tc_code), .adc_cj_code(cj_code), .fault_in(fault_in)
  );

  tcr_host u_host (.sck(sck), .cs_n(cs_n), .so(so), .so_oe(so_oe));

  // Converter stand-in: answers every start one cycle later with the held codes.
  always @(posedge clk) adc_valid <= adc_start;

  // While a conversion runs, the minus input is grounded, fault paths are open and exactly one path feeds it.
  always @(posedge clk) begin
    if (adc_valid === 1'b1)
      cmp_bit(switches.tminus_gnd && !switches.fault_pos && !switches.fault_neg &&
              (switches.tc_to_adc ^ switches.cj_to_adc), 1'b1);
  end

  // Expected word from the codes; saturation and the open pattern follow the result format.
  function automatic logic [31:0] exp_word(input logic signed [17:0] t, input logic signed [11:0] c,
                                           input logic [2:0] f);
    longint     v;
    logic [13:0] r;
    v = ((longint'(t) * longint'(TC_GAIN_NUM)) >>> TC_GAIN_SHIFT) + (longint'(c) >>> 2);
    r = (v > 64'sh1FFF) ? TC_MAX : (v < -64'sh2000) ? TC_MIN : v[13:0];
    if (f[0]) r = TC_OPEN_PATTERN;
    return {r, 1'b0, |f, c, 1'b0, f};
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Inputs change at the rising edge by non-blocking assignment.
  task automatic drive(input logic [17:0] t, input logic [11:0] c, input logic [2:0] f);
    @(posedge clk);
    tc_code <= t;
    cj_code <= c;
    fault_in <= f;
  endtask

  // Note the expected snapshot, then let the host read n bits; enable must track chip select.
  task automatic rd(input int n);
    exp_q.push_back(exp_word(tc_code, cj_code, fault_in) >> (32 - n));
    u_host.read(n);
    cmp_bit(u_host.oe_all, 1'b1);
    cmp_bit(so_oe, 1'b0);
  endtask

  // Each finished read is compared against the oldest note.
  always @(u_host.got) begin
    if (exp_q.size() > 0)
      cmp_word(u_host.rx_word, exp_q.pop_front());
    else
      cmp_word(u_host.rx_word, 32'hFFFF_FFFF);
  end

  // Hang guard sized well above the planned run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    tc_code = 18'h00000;
    cj_code = 12'h000;
    fault_in = 3'h0;
    seed = 62;
    n_fail = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Random codes plus both saturation ends, full reads.
    for (int i = 0; i < 6; i++) begin
      drive((i == 4) ? 18'h1FFFF : (i == 5) ? 18'h20000 : 18'($random(seed)), 12'($random(seed)), 3'h0);
      // A random stretch with the clock enable low must only pause the sequencer.
      ce <= 1'b0;
      repeat (($random(seed) & 15) + 1) @(posedge clk);
      ce <= 1'b1;
      repeat (SETTLE) @(posedge clk);
      rd(32);
    end
    $display("test codes done");
    // Every fault combination, then the clean case to see the flags clear.
    for (int i = 0; i < 8; i++) begin
      drive(18'($random(seed) & 18'h03FFF), 12'($random(seed)), 3'((i + 1) % 8));
      repeat (SETTLE) @(posedge clk);
      rd(32);
    end
    $display("test faults done");
    // Short reads and clock edges while deselected.
    drive(18'($random(seed)), 12'($random(seed)), 3'h0);
    repeat (SETTLE) @(posedge clk);
    rd(14);
    rd(5);
    u_host.idle_clocks(3);
    rd(9);
    $display("test truncation done");
    // New results arrive during a read; the transfer must stay on the old snapshot.
    fork
      rd(32);
      begin
        repeat (150) @(posedge clk);
        drive(18'($random(seed)), 12'($random(seed)), 3'h2);
      end
    join
    repeat (SETTLE) @(posedge clk);
    rd(32);
    $display("test snapshot done");
    summarize();
  end
endmodule
